// File: rtl/opr_otp_core.sv
// Contract
// - Seventeen security registers, each locked on its own.
// - Register 0: factory 64-bit number, blank user half; others blank.
// - Programmed bits never erase; unlocked registers take more programs.
// - Programmed lock bit makes its register read-only forever.
// - Identifier-read state returns one 16-bit word per read.
// - Device programs one 16-bit word per program operation.
// - Program outside security space refused, sets program-error bit 4.
// - Program to locked register refused, sets status bits 4 and 1.
// - Lock word 0 at offset 0x80, lock word 1 at 0x89.
// - Lock word 0 bit 0 comes programmed, factory segment read-only.
// - Each lock word 1 bit locks one of the upper sixteen registers.
// - Four main-array areas may be set to refuse program and erase.
// - Areas: blocks 3:0,4,5,6 bottom; highest seven blocks on top.
// - Full option refuses program and erase on every block.
// - Status bits 1, 3, 4 stay set until clear-status command.
module opr_otp_core
    import opr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire logic [8:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] arr_rdata,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic vpp_ok,
    input wire logic top_param,
    input wire logic [8:0] last_blk,
    input wire logic [3:0] otp_area_en,
    input wire logic otp_full_en,
    input wire logic blk_req,
    input wire logic [8:0] blk_num,
    output logic blk_deny,
    output logic ready
);
    localparam logic [7:0] FACT_IDX = 8'(FACT_OFS - LOCK0_OFS);
    localparam logic [7:0] USER0_IDX = 8'(USER0_OFS - LOCK0_OFS);
    localparam logic [7:0] LOCK1_IDX = 8'(LOCK1_OFS - LOCK0_OFS);
    localparam logic [7:0] PR1_IDX = 8'(PR1_OFS - LOCK0_OFS);
    localparam logic [7:0] SEG_WORDS = 8'(PR_WORDS / 2);
    localparam int PROG_WAIT = PROG_CYCLES + 1;

    opr_store_if st ();
    opr_mode_e mode_q, mode_d;
    logic [8:0] tgt_q;
    logic [15:0] pdata_q;
    logic prog_err_q, lock_err_q, supply_err_q;
    logic [15:0] bus_rdata_q;
    logic bus_rvalid_q;
    logic blk_deny_q;
    logic tmr_busy, tmr_done;
    wire prog_start;

    // all checks run on the one clock, idle during reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    opr_word_store u_store (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .st(st)
    );

    opr_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(prog_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // address decode of the security word space
    wire addr_in_space = (bus_addr >= LOCK0_OFS) && (bus_addr <= LAST_OFS);
    wire [8:0] addr_rel = bus_addr - LOCK0_OFS;
    wire [7:0] rd_idx = addr_rel[7:0];
    wire tgt_in_space = (tgt_q >= LOCK0_OFS) && (tgt_q <= LAST_OFS);
    wire [8:0] tgt_rel = tgt_q - LOCK0_OFS;
    wire [7:0] tgt_idx = tgt_rel[7:0];

    // which lock bit guards the target word
    wire in_fact = (tgt_idx >= FACT_IDX) && (tgt_idx < USER0_IDX);
    wire in_user0 = (tgt_idx >= USER0_IDX) && (tgt_idx < LOCK1_IDX);
    wire in_pr = (tgt_idx >= PR1_IDX);
    wire [7:0] pr_rel = tgt_idx - PR1_IDX;
    wire [3:0] pr_sel = pr_rel[6:3];
    wire fact_locked = in_fact && !st.lock0[LOCK0_FACT_BIT];
    wire user0_locked = in_user0 && !st.lock0[LOCK0_USER_BIT];
    wire pr_locked = in_pr && !st.lock1[pr_sel];
    wire tgt_locked = fact_locked || user0_locked || pr_locked;

    // command decode, only while no program is pending
    wire [7:0] cmd = bus_wdata[7:0];
    wire idle_mode = (mode_q == OPR_ARRAY) || (mode_q == OPR_IDENT)
                  || (mode_q == OPR_STATUS);
    wire cmd_wr = bus_we && idle_mode;
    wire clr_status = cmd_wr && (cmd == CMD_CLEAR_STATUS);
    wire data_wr = bus_we && (mode_q == OPR_SETUP);

    // outcome of the data write after the program command
    wire set_prog_oos = data_wr && !tgt_in_space;
    wire set_locked = data_wr && tgt_in_space && tgt_locked;
    wire set_supply = data_wr && tgt_in_space && !tgt_locked && !vpp_ok;
    assign prog_start = data_wr && tgt_in_space && !tgt_locked && vpp_ok;
    wire set_prog = set_prog_oos || set_locked || set_supply;

    // status word, ready is low only while a word is being programmed
    wire [15:0] status_word = {8'h00, ready, 2'b00, prog_err_q,
                               supply_err_q, 1'b0, lock_err_q, 1'b0};
    assign ready = (mode_q != OPR_BUSY);

    // mode sequencing
    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            OPR_ARRAY, OPR_IDENT, OPR_STATUS:
            begin
                if (bus_we)
                begin
                    case (cmd)
                        CMD_READ_ARRAY: mode_d = OPR_ARRAY;
                        CMD_READ_ID: mode_d = OPR_IDENT;
                        CMD_READ_STATUS: mode_d = OPR_STATUS;
                        CMD_PROG_OTP: mode_d = OPR_SETUP;
                        default: mode_d = mode_q;
                    endcase
                end
            end
            OPR_SETUP:
            begin
                if (prog_start)
                    mode_d = OPR_BUSY;
                else if (bus_we)
                    mode_d = OPR_STATUS;
            end
            OPR_BUSY:
            begin
                if (tmr_done)
                    mode_d = OPR_STATUS;
            end
            default: mode_d = OPR_ARRAY;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            mode_q <= OPR_ARRAY;
        else
            mode_q <= mode_d;
    end

    // target offset from the command write, data from the next write
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tgt_q <= '0;
            pdata_q <= ERASED_WORD;
        end
        else if (cmd_wr && cmd == CMD_PROG_OTP)
            tgt_q <= bus_addr;
        else if (prog_start)
            pdata_q <= bus_wdata;
    end

    // one 16-bit word lands when the program time has run out
    assign st.wr = (mode_q == OPR_BUSY) && tmr_done;
    assign st.widx = tgt_idx;
    assign st.wdata = pdata_q;
    assign st.ridx = rd_idx;

    // sticky error bits, a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prog_err_q <= 1'b0;
            lock_err_q <= 1'b0;
            supply_err_q <= 1'b0;
        end
        else
        begin
            prog_err_q <= set_prog || (prog_err_q && !clr_status);
            lock_err_q <= set_locked || (lock_err_q && !clr_status);
            supply_err_q <= set_supply || (supply_err_q && !clr_status);
        end
    end

    // read data source per mode
    wire [15:0] ident_word = addr_in_space ? st.rdata : 16'h0000;
    wire [15:0] rd_sel = (mode_q == OPR_ARRAY) ? arr_rdata :
                         (mode_q == OPR_IDENT) ? ident_word : status_word;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_rdata_q <= 16'h0000;
            bus_rvalid_q <= 1'b0;
        end
        else
        begin
            bus_rvalid_q <= bus_re;
            if (bus_re)
                bus_rdata_q <= rd_sel;
        end
    end

    assign bus_rdata = bus_rdata_q;
    assign bus_rvalid = bus_rvalid_q;

    // selectable permanent main-array areas
    wire [8:0] top_param_lo = last_blk - 9'(PARAM_BLOCKS - 1);
    wire [8:0] bot_param_hi = 9'(PARAM_BLOCKS - 1);
    wire [OTP_AREAS-1:0] area_hit;
    assign area_hit[0] = top_param ? (blk_num >= top_param_lo)
                                   : (blk_num <= bot_param_hi);
    genvar g;
    generate
        for (g = 1; g < OTP_AREAS; g++)
        begin : g_main_area
            assign area_hit[g] = top_param
                ? (blk_num == top_param_lo - 9'(g))
                : (blk_num == bot_param_hi + 9'(g));
        end
    endgenerate
    wire blk_refuse = otp_full_en
                   || |(otp_area_en & area_hit);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            blk_deny_q <= 1'b0;
        else
            blk_deny_q <= blk_req && blk_refuse;
    end

    assign blk_deny = blk_deny_q;

    // checks
    sequence s_prog_go;
        mode_q == OPR_SETUP && bus_we && tgt_in_space && !tgt_locked && vpp_ok;
    endsequence
    sequence s_word_lands;
        st.wr && st.widx == $past(tgt_idx);
    endsequence
    sequence s_refused;
        data_wr && !prog_start;
    endsequence

    // lock bits only ever go from one to zero
    lock_otp_a: assert property (
        (st.lock0 & ~$past(st.lock0)) == 16'h0000
        && (st.lock1 & ~$past(st.lock1)) == 16'h0000)
        else $error("lock bit went back to one");

    // factory segment stays locked
    fact_lock_a: assert property (!st.lock0[LOCK0_FACT_BIT])
        else $error("factory segment lock bit is not programmed");

    // out of space program refused with program error
    oos_err_a: assert property (
        (data_wr && !tgt_in_space)
        |=> prog_err_q && mode_q == OPR_STATUS && !tmr_busy)
        else $error("out of space program not refused");

    // locked target refused with both errors
    locked_err_a: assert property (
        (data_wr && tgt_in_space && tgt_locked)
        |=> prog_err_q && lock_err_q && ready)
        else $error("locked program not refused with both errors");

    // supply fault sets its own bit and the program bit
    supply_err_a: assert property (
        (data_wr && tgt_in_space && !tgt_locked && !vpp_ok)
        |=> supply_err_q && prog_err_q && ready)
        else $error("supply fault not reported");

    // refused data writes never start the program timer
    refuse_idle_a: assert property (
        s_refused |=> !tmr_busy && !st.wr)
        else $error("refused program still started");

    // accepted word lands at its latched offset
    prog_word_a: assert property (
        s_prog_go |-> ##[1:PROG_WAIT] s_word_lands)
        else $error("program word never written");

    // ready low for the first eight cycles of the program
    busy_flag_a: assert property (s_prog_go |=> !ready [*8])
        else $error("ready not low during program");

    // ready back and status shown once program time is over
    ready_back_a: assert property (
        s_prog_go
        |-> ##[PROG_WAIT:PROG_WAIT] (ready && mode_q == OPR_STATUS))
        else $error("ready not back after program time");

    // writes while busy leave target and data alone
    busy_ignore_a: assert property (
        (mode_q == OPR_BUSY && bus_we)
        |=> $stable(tgt_q) && $stable(pdata_q))
        else $error("write during program was taken");

    // error bits hold until clear-status
    err_sticky_a: assert property (
        ((prog_err_q || lock_err_q || supply_err_q) && !clr_status)
        |=> (prog_err_q >= $past(prog_err_q))
        && (lock_err_q >= $past(lock_err_q))
        && (supply_err_q >= $past(supply_err_q)))
        else $error("error bit cleared without clear command");

    // clear-status empties every error bit
    err_clear_a: assert property (
        (clr_status && !set_prog)
        |=> !prog_err_q && !lock_err_q && !supply_err_q)
        else $error("clear status left an error bit set");

    // one valid pulse per read strobe
    rvalid_pulse_a: assert property (bus_rvalid == $past(bus_re))
        else $error("read valid not one cycle after strobe");

    // identifier read returns the stored word
    ident_read_a: assert property (
        (bus_re && mode_q == OPR_IDENT && addr_in_space)
        |=> bus_rvalid && bus_rdata == $past(st.rdata))
        else $error("identifier read word mismatch");

    // enabled area refuses program and erase
    area_deny_a: assert property (
        (blk_req && |(otp_area_en & area_hit)) |=> blk_deny)
        else $error("enabled otp area did not refuse");

    // blocks outside every enabled area pass
    area_pass_a: assert property (
        (blk_req && !blk_refuse) |=> !blk_deny)
        else $error("free block refused");

    // full option refuses every block
    full_deny_a: assert property (
        (blk_req && otp_full_en) |=> blk_deny)
        else $error("full array option did not refuse");
endmodule

// File: rtl/opr_pkg.sv
package opr_pkg;
    // window of the security word space, in word offsets
    localparam logic [8:0] LOCK0_OFS = 9'h080;
    localparam logic [8:0] FACT_OFS = 9'h081;
    localparam logic [8:0] USER0_OFS = 9'h085;
    localparam logic [8:0] LOCK1_OFS = 9'h089;
    localparam logic [8:0] PR1_OFS = 9'h08A;
    localparam logic [8:0] PR16_OFS = 9'h102;
    localparam logic [8:0] LAST_OFS = 9'h109;
    localparam int WORDS = 138;
    localparam int NUM_SEC_REGS = 17;
    localparam int PR_WORDS = 8;
    // reset and blank values
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [15:0] LOCK0_RESET = 16'hFFFE;
    // arbitrary stand-in for the factory unique number
    localparam logic [63:0] FACTORY_ID = 64'h0123_4567_89AB_CDEF;
    // lock word 0 fields
    localparam int LOCK0_FACT_BIT = 0;
    localparam int LOCK0_USER_BIT = 1;
    // command codes, low byte of a write
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROG_OTP = 8'hC0;
    // status word bit positions
    localparam int SB_READY = 7;
    localparam int SB_PROG_ERR = 4;
    localparam int SB_SUPPLY_ERR = 3;
    localparam int SB_LOCK_ERR = 1;
    // program time, least time rounded up to clock cycles
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 2000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    // selectable main-array areas
    localparam int PARAM_BLOCKS = 4;
    localparam int OTP_AREAS = 4;
    typedef enum {OPR_ARRAY, OPR_IDENT, OPR_STATUS, OPR_SETUP, OPR_BUSY}
        opr_mode_e;
endpackage

// File: rtl/opr_store_if.sv
interface opr_store_if;
    logic wr;
    logic [7:0] widx;
    logic [15:0] wdata;
    logic [7:0] ridx;
    logic [15:0] rdata;
    logic [15:0] lock0;
    logic [15:0] lock1;
    modport ctl (output wr, widx, wdata, ridx, input rdata, lock0, lock1);
    modport mem (input wr, widx, wdata, ridx, output rdata, lock0, lock1);
endinterface

// File: rtl/opr_word_store.sv
module opr_word_store
    import opr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    opr_store_if.mem st
);
    logic [15:0] mem_q [WORDS];

    // power-on content: factory words, pre-locked word 0, rest blank
    function automatic logic [15:0] init_word(input int i);
        int f;
        f = i - int'(FACT_OFS - LOCK0_OFS);
        if (i == 0)
            return LOCK0_RESET;
        else if (f >= 0 && f < 4)
            return FACTORY_ID[16*f +: 16];
        else
            return ERASED_WORD;
    endfunction

    // program only clears bits, nothing ever sets one again
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < WORDS; i++)
                mem_q[i] <= init_word(i);
        end
        else if (st.wr)
            mem_q[st.widx] <= mem_q[st.widx] & st.wdata;
    end

    // read port and lock words
    assign st.rdata = (int'(st.ridx) < WORDS) ? mem_q[st.ridx] : ERASED_WORD;
    assign st.lock0 = mem_q[0];
    assign st.lock1 = mem_q[int'(LOCK1_OFS - LOCK0_OFS)];
endmodule

// File: rtl/opr_prog_timer.sv
module opr_prog_timer #(
    parameter int CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    logic [CW-1:0] cnt_q;

    // counts down the program time, done pulses on the last cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= '0;
        else if (start)
            cnt_q <= LOAD;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - CW'(1);
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == CW'(1));
endmodule

// File: verification/opr_host_model.sv
// host side of the command bus: word writes, word reads, otp programs
module opr_host_model (
    input wire logic sys_clk,
    output logic bus_we,
    output logic bus_re,
    output logic [8:0] bus_addr,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial
    begin
        bus_we = 1'b0;
        bus_re = 1'b0;
        bus_addr = 9'h000;
        bus_wdata = 16'h0000;
    end

    // one write cycle; released lines show the inverse, never stale data
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        bus_we = 1'b1;
        bus_addr = a;
        bus_wdata = d;
        @(negedge sys_clk);
        bus_we = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask

    // one read cycle, data taken while the valid pulse stands
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        int n;
        @(negedge sys_clk);
        bus_re = 1'b1;
        bus_addr = a;
        @(negedge sys_clk);
        bus_re = 1'b0;
        bus_addr = ~a;
        n = 0;
        while (bus_rvalid !== 1'b1 && n < 4)
        begin
            @(negedge sys_clk);
            n++;
        end
        d = (bus_rvalid === 1'b1) ? bus_rdata : 16'hXXXX;
    endtask

    // setup write and data write at the same offset, then status poll
    // offset bus only, no upper address lines to hold high on top parts
    task automatic prog(input logic [8:0] a, input logic [15:0] d,
                        output logic [15:0] st);
        int n;
        wr(a, 16'h00C0);
        wr(a, d);
        n = 0;
        st = 16'h0000;
        // wait for ready before anything else is issued
        while (st[7] !== 1'b1 && n < 300)
        begin
            rd(a, st);
            n++;
        end
    endtask
endmodule

// File: verification/otp_protection_register_logic_tb.sv
module otp_protection_register_logic_tb import opr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] ST_OK = 16'h0080;
    localparam logic [15:0] ST_PE = 16'h0090;
    localparam logic [15:0] ST_LK = 16'h0092;
    localparam logic [15:0] ST_VP = 16'h0098;

    logic sys_clk, rstn, bus_we, bus_re, bus_rvalid, vpp_ok, top_param;
    logic otp_full_en, blk_req, blk_deny, ready;
    logic [8:0] bus_addr, last_blk, blk_num;
    logic [15:0] bus_wdata, arr_rdata, bus_rdata, st;
    logic [3:0] otp_area_en;
    int failures = 0;
    int checked = 0;

    opr_otp_core opr_otp_core_inst (.sys_clk(sys_clk), .rstn(rstn),
        .bus_we(bus_we), .bus_re(bus_re), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .arr_rdata(arr_rdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .vpp_ok(vpp_ok),
        .top_param(top_param), .last_blk(last_blk),
        .otp_area_en(otp_area_en), .otp_full_en(otp_full_en),
        .blk_req(blk_req), .blk_num(blk_num), .blk_deny(blk_deny),
        .ready(ready));

    opr_host_model opr_host_model_inst (.sys_clk(sys_clk), .bus_we(bus_we),
        .bus_re(bus_re), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));

    // 50 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // bus read of one word in the current mode against its expected value
    task automatic rdchk(input logic [8:0] a, input logic [15:0] exp,
                         input string name);
        logic [15:0] v;
        opr_host_model_inst.rd(a, v);
        check(name, v, exp);
    endtask

    task automatic cmd(input logic [15:0] c);
        opr_host_model_inst.wr(9'h000, c);
    endtask

    task automatic pchk(input logic [8:0] a, input logic [15:0] d,
                        input logic [15:0] exp, input string name);
        opr_host_model_inst.prog(a, d, st);
        check(name, st, exp);
    endtask

    // array program/erase request and its refusal flag
    task automatic blk(input logic [8:0] num, input logic exp);
        @(negedge sys_clk);
        blk_req = 1'b1;
        blk_num = num;
        @(negedge sys_clk);
        blk_req = 1'b0;
        check("blk_deny", {15'h0000, blk_deny}, {15'h0000, exp});
    endtask

    // 40000 cycles, several times the expected length of the sequence
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        logic [8:0] base, lo;
        rstn = 1'b0;
        arr_rdata = 16'hA55A;
        vpp_ok = 1'b1;
        top_param = 1'b0;
        last_blk = 9'd66;
        otp_area_en = 4'h0;
        otp_full_en = 1'b0;
        blk_req = 1'b0;
        blk_num = 9'h000;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        check("ready", {15'h0000, ready}, 16'h0001);
        // reset contents of the security space
        cmd(16'h0090);
        rdchk(LOCK0_OFS, LOCK0_RESET, "lock0");
        for (int i = 0; i < 4; i++)
            rdchk(FACT_OFS + 9'(i), FACTORY_ID[16*i +: 16], "fact");
        rdchk(USER0_OFS, ERASED_WORD, "user0");
        rdchk(LAST_OFS, ERASED_WORD, "last");
        rdchk(LAST_OFS + 9'h001, 16'h0000, "outside");
        cmd(16'h00FF);
        rdchk(9'h010, 16'hA55A, "array");
        // repeated programs only clear further bits
        pchk(PR1_OFS, 16'h1234, ST_OK, "prog1");
        pchk(PR1_OFS, 16'hFF0F, ST_OK, "prog2");
        pchk(PR1_OFS, 16'hFFFF, ST_OK, "prog3");
        cmd(16'h0090);
        rdchk(PR1_OFS, 16'h1204, "and");
        // program outside the space, error held until clear
        pchk(LAST_OFS + 9'h001, 16'h0000, ST_PE, "outprog");
        cmd(16'h00FF);
        cmd(16'h0070);
        rdchk(9'h000, ST_PE, "held");
        cmd(16'h0050);
        cmd(16'h0070);
        rdchk(9'h000, ST_OK, "cleared");
        // supply fault refuses the program
        vpp_ok = 1'b0;
        pchk(PR16_OFS, 16'h0000, ST_VP, "vpp");
        vpp_ok = 1'b1;
        cmd(16'h0050);
        cmd(16'h0090);
        rdchk(PR16_OFS, ERASED_WORD, "vppword");
        // user segment lock and factory segment
        pchk(LOCK0_OFS, 16'hFFFD, ST_OK, "lockuser");
        pchk(USER0_OFS + 9'h003, 16'h0000, ST_LK, "userlk");
        cmd(16'h0050);
        pchk(FACT_OFS, 16'h0000, ST_LK, "factlk");
        cmd(16'h0050);
        cmd(16'h0090);
        rdchk(LOCK0_OFS, 16'hFFFC, "lock0w");
        rdchk(USER0_OFS + 9'h003, ERASED_WORD, "userw");
        rdchk(FACT_OFS, FACTORY_ID[15:0], "factw");
        // each lock word 1 bit locks its own register only
        for (int n = 0; n < 16; n++)
        begin
            base = PR1_OFS + 9'(8 * n);
            pchk(base + 9'h001, 16'h00FF, ST_OK, "free");
            pchk(LOCK1_OFS, ~(16'h0001 << n), ST_OK, "lock1");
            pchk(base + 9'h007, 16'h0000, ST_LK, "reglk");
            cmd(16'h0050);
            cmd(16'h0090);
            rdchk(base + 9'h001, 16'h00FF, "regw");
            rdchk(base + 9'h007, ERASED_WORD, "lkw");
        end
        // selectable areas, both parameter placements
        for (int t = 0; t < 2; t++)
        begin
            top_param = t[0];
            for (int a = 0; a < 4; a++)
            begin
                otp_area_en = 4'h1 << a;
                lo = t ? 9'(a == 0 ? 63 : 63 - a) : 9'(a == 0 ? 0 : 3 + a);
                blk(lo, 1'b1);
                blk(a == 0 ? lo + 9'd3 : lo, 1'b1);
                blk(t ? 9'd59 : 9'd7, 1'b0);
            end
        end
        otp_area_en = 4'h0;
        blk(9'd30, 1'b0);
        otp_full_en = 1'b1;
        blk(9'd30, 1'b1);
        blk(9'd66, 1'b1);
        print_verdict();
    end
endmodule
